// file: core/asq_defines.svh
`ifndef ASQ_DEFINES_SVH
`define ASQ_DEFINES_SVH

`define ASQ_CON1_ADDR 32'hBF80_9000
`define ASQ_CON2_ADDR 32'hBF80_9010
`define ASQ_CON3_ADDR 32'hBF80_9020
`define ASQ_CHS_ADDR 32'hBF80_9040
`define ASQ_CSSL_ADDR 32'hBF80_9050
`define ASQ_BUF0_ADDR 32'hBF80_9070
`define ASQ_INTERRUPT_FLAG_STATUS_1_ADDR 32'hBF88_1040
`define ASQ_INTERRUPT_ENABLE_CONTROL_1_ADDR 32'hBF88_1070
`define ASQ_INTERRUPT_PRIORITY_CONTROL_6_ADDR 32'hBF88_10F0

`define ASQ_ON_BIT 15
`define ASQ_FRZ_BIT 14
`define ASQ_STOP_IN_IDLE_BIT 13
`define ASQ_FORM_LSB 8
`define ASQ_TRIG_LSB 5
`define ASQ_STOP_AFTER_FIRST_IRQ_BIT 4
`define ASQ_AUTO_SAMPLE_START_BIT 2
`define ASQ_SAMPLE_BIT_BIT 1
`define ASQ_DONE_BIT 0
`define ASQ_VCFG_LSB 13
`define ASQ_OFFSET_CALIBRATION_MODE_BIT 12
`define ASQ_SCAN_BIT 10
`define ASQ_SMPI_LSB 2
`define ASQ_BUFFER_SPLIT_MODE_BIT 1
`define ASQ_ALTERNATE_INPUT_MODE_BIT 0
`define ASQ_ADRC_BIT 15
`define ASQ_SAMC_LSB 8
`define ASQ_CHSB_LSB 24
`define ASQ_CHSA_LSB 16
`define ASQ_IRQ_BIT 1
`define ASQ_PRIO_LSB 26
`define ASQ_SUB_LSB 24

`define ASQ_RESET_WORD 32'h0000_0000

`endif

// file: core/asq_fmt.sv
`timescale 1ns/10ps
module asq_fmt (
	input asq_pkg::asq_form_e form_i,
	input wire logic [9:0] data_i,
	output logic [31:0] word_o
);
	import asq_pkg::*;

	// Signed forms treat the raw code as offset binary, so the top bit flips
	always_comb begin
		unique case (form_i)
			ASQ_FMT_FRAC16: word_o = {16'h0000, data_i, 6'h00};
			ASQ_FMT_SFRAC16: word_o = {16'h0000, ~data_i[9], data_i[8:0], 6'h00};
			ASQ_FMT_SINT32: word_o = {{22{~data_i[9]}}, ~data_i[9], data_i[8:0]};
			ASQ_FMT_SFRAC32: word_o = {~data_i[9], data_i[8:0], 22'h00_0000};
			default: word_o = {22'h00_0000, data_i};
		endcase
	end
endmodule

// file: core/asq_pkg.sv
package asq_pkg;
	typedef enum logic [1:0] {
		ASQ_HOLD = 2'h0,
		ASQ_SAMPLE = 2'h1,
		ASQ_CONVERT = 2'h3
	} asq_state_e;
	typedef enum logic [2:0] {
		ASQ_TRIG_SW = 3'h0,
		ASQ_TRIG_EXTERNAL_INTERRUPT_PIN_ZERO = 3'h1,
		ASQ_TRIG_TMR3 = 3'h2,
		ASQ_TRIG_AUTO = 3'h7
	} asq_trig_e;
	typedef enum logic [2:0] {
		ASQ_FMT_INT16 = 3'h0,
		ASQ_FMT_FRAC16 = 3'h2,
		ASQ_FMT_SFRAC16 = 3'h3,
		ASQ_FMT_INT32 = 3'h4,
		ASQ_FMT_SINT32 = 3'h5,
		ASQ_FMT_SFRAC32 = 3'h7
	} asq_form_e;
endpackage

// file: core/asq_tad.sv
`timescale 1ns/10ps
module asq_tad (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic run_i,
	input wire logic [7:0] div_i,
	output logic tick_o
);
	logic [8:0] cnt_q;

	// Period of 2*(div+1) bus clocks; restarts whenever run drops
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || !run_i) begin
			cnt_q <= 9'h000;
			tick_o <= 1'h0;
		end else if (cnt_q == {div_i, 1'h1}) begin
			cnt_q <= 9'h000;
			tick_o <= 1'h1;
		end else begin
			cnt_q <= cnt_q + 9'h001;
			tick_o <= 1'h0;
		end
	end
endmodule

// file: core/asq_top.sv
`timescale 1ns/10ps
`include "asq_defines.svh"
module asq_top (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic debug_mode_i,
	input wire logic idle_mode_i,
	input wire logic timer3_match_i,
	input wire logic ext_external_interrupt_pin_zero_i,
	input wire logic conv_done_i,
	input wire logic [9:0] conv_data_i,
	output logic [31:0] rdata_o,
	output logic sample_o,
	output logic conv_start_o,
	output logic [3:0] chan_pos_o,
	output logic offset_cal_o,
	output logic [1:0] ref_sel_o,
	output logic irq_req_o,
	output logic [2:0] irq_prio_o,
	output logic [1:0] irq_sub_o
);
	import asq_pkg::*;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	logic on_q, frz_q, stop_in_idle_q, stop_after_first_irq_q, auto_sample_start_q, done_q;
	asq_form_e form_q;
	asq_trig_e trig_q;
	logic [2:0] vcfg_q;
	logic offset_calibration_mode_q, scan_en_q, buffer_fill_status_q, buffer_split_mode_q, alternate_input_mode_q, adrc_q;
	logic [3:0] smpi_q, chsa_q, chsb_q;
	logic [4:0] samc_q, smp_cnt_q;
	logic [7:0] div_q;
	logic [15:0] cssl_q;
	logic flag_q, ien_q, external_interrupt_pin_zero_q;
	asq_state_e state_q, state_d;
	logic start_conv, end_smp, run, cdone, irq_ev, smp_start, tad_tick;
	logic w1, w2, w3, wch, wcs, wfl, wen, wpr, bhit;
	logic [31:0] boff, rd_val, fmt_word;
	logic [3:0] seq_q, fill_q, scan_idx_q, widx;
	logic use_b_q;
	logic [9:0] res_q [16];

	// Lowest set mask bit after cur, wrapping; cur itself when it is the only one
	function automatic logic [3:0] asq_next(input logic [15:0] m, input logic [3:0] cur);
		logic [3:0] k;
		asq_next = cur;
		for (int i = 16; i >= 1; i--) begin
			k = cur + i[3:0];
			if (m[k]) begin
				asq_next = k;
			end
		end
	endfunction

	assign w1 = wr_i && addr_i == `ASQ_CON1_ADDR;
	assign w2 = wr_i && addr_i == `ASQ_CON2_ADDR;
	assign w3 = wr_i && addr_i == `ASQ_CON3_ADDR;
	assign wch = wr_i && addr_i == `ASQ_CHS_ADDR;
	assign wcs = wr_i && addr_i == `ASQ_CSSL_ADDR;
	assign wfl = wr_i && addr_i == `ASQ_INTERRUPT_FLAG_STATUS_1_ADDR;
	assign wen = wr_i && addr_i == `ASQ_INTERRUPT_ENABLE_CONTROL_1_ADDR;
	assign wpr = wr_i && addr_i == `ASQ_INTERRUPT_PRIORITY_CONTROL_6_ADDR;
	assign boff = addr_i - `ASQ_BUF0_ADDR;
	assign bhit = boff[31:8] == 24'h00_0000 && boff[3:0] == 4'h0;

	assign run = on_q && !(stop_in_idle_q && idle_mode_i) && !(frz_q && debug_mode_i);
	assign cdone = conv_done_i && state_q == ASQ_CONVERT;
	assign irq_ev = cdone && seq_q == smpi_q;
	assign smp_start = state_q != ASQ_SAMPLE && state_d == ASQ_SAMPLE;
	assign widx = buffer_split_mode_q ? {buffer_fill_status_q, fill_q[2:0]} : fill_q;

	// Control registers; reserved bits are never stored
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			on_q <= 1'h0;
			frz_q <= 1'h0;
			stop_in_idle_q <= 1'h0;
			form_q <= ASQ_FMT_INT16;
			trig_q <= ASQ_TRIG_SW;
			stop_after_first_irq_q <= 1'h0;
			vcfg_q <= 3'h0;
			offset_calibration_mode_q <= 1'h0;
			scan_en_q <= 1'h0;
			smpi_q <= 4'h0;
			buffer_split_mode_q <= 1'h0;
			alternate_input_mode_q <= 1'h0;
		end else begin
			if (w1) begin
				on_q <= wdata_i[`ASQ_ON_BIT];
				stop_in_idle_q <= wdata_i[`ASQ_STOP_IN_IDLE_BIT];
				form_q <= asq_form_e'(wdata_i[`ASQ_FORM_LSB+:3]);
				trig_q <= asq_trig_e'(wdata_i[`ASQ_TRIG_LSB+:3]);
				stop_after_first_irq_q <= wdata_i[`ASQ_STOP_AFTER_FIRST_IRQ_BIT];
			end
			if (w1 && debug_mode_i) begin
				frz_q <= wdata_i[`ASQ_FRZ_BIT];
			end
			if (w2) begin
				vcfg_q <= wdata_i[`ASQ_VCFG_LSB+:3];
				offset_calibration_mode_q <= wdata_i[`ASQ_OFFSET_CALIBRATION_MODE_BIT];
				scan_en_q <= wdata_i[`ASQ_SCAN_BIT];
				smpi_q <= wdata_i[`ASQ_SMPI_LSB+:4];
				buffer_split_mode_q <= wdata_i[`ASQ_BUFFER_SPLIT_MODE_BIT];
				alternate_input_mode_q <= wdata_i[`ASQ_ALTERNATE_INPUT_MODE_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			adrc_q <= 1'h0;
			samc_q <= 5'h00;
			div_q <= 8'h00;
			chsa_q <= 4'h0;
			chsb_q <= 4'h0;
			cssl_q <= 16'h0000;
			ien_q <= 1'h0;
			irq_prio_o <= 3'h0;
			irq_sub_o <= 2'h0;
		end else begin
			if (w3) begin
				adrc_q <= wdata_i[`ASQ_ADRC_BIT];
				samc_q <= wdata_i[`ASQ_SAMC_LSB+:5];
				div_q <= wdata_i[7:0];
			end
			if (wch) begin
				chsa_q <= wdata_i[`ASQ_CHSA_LSB+:4];
				chsb_q <= wdata_i[`ASQ_CHSB_LSB+:4];
			end
			if (wcs) begin
				cssl_q <= wdata_i[15:0];
			end
			if (wen) begin
				ien_q <= wdata_i[`ASQ_IRQ_BIT];
			end
			if (wpr) begin
				irq_prio_o <= wdata_i[`ASQ_PRIO_LSB+:3];
				irq_sub_o <= wdata_i[`ASQ_SUB_LSB+:2];
			end
		end
	end

	// Hardware clear takes priority over a same-cycle software write, so a stop at the interrupt always lands
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			auto_sample_start_q <= 1'h0;
		end else if (irq_ev && stop_after_first_irq_q) begin
			auto_sample_start_q <= 1'h0;
		end else if (w1) begin
			auto_sample_start_q <= wdata_i[`ASQ_AUTO_SAMPLE_START_BIT];
		end
	end

	// Completion sets; a software clear or auto resample clears, set wins
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			done_q <= 1'h0;
		end else if (cdone) begin
			done_q <= 1'h1;
		end else if ((w1 && !wdata_i[`ASQ_DONE_BIT]) || (smp_start && auto_sample_start_q)) begin
			done_q <= 1'h0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			flag_q <= 1'h0;
			irq_req_o <= 1'h0;
		end else begin
			if (irq_ev) begin
				flag_q <= 1'h1;
			end else if (wfl) begin
				flag_q <= wdata_i[`ASQ_IRQ_BIT];
			end
			irq_req_o <= flag_q && ien_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			external_interrupt_pin_zero_q <= 1'h0;
		end else begin
			external_interrupt_pin_zero_q <= ext_external_interrupt_pin_zero_i;
		end
	end

	asq_tad u_tad (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.run_i(run && state_q == ASQ_SAMPLE && trig_q == ASQ_TRIG_AUTO),
		.div_i(div_q),
		.tick_o(tad_tick)
	);

	// A zero sample time is illegal; it is run as one period
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || state_q != ASQ_SAMPLE) begin
			smp_cnt_q <= 5'h00;
		end else if (tad_tick) begin
			smp_cnt_q <= smp_cnt_q + 5'h01;
		end
	end

	always_comb begin
		unique case (trig_q)
			ASQ_TRIG_SW: end_smp = w1 && !wdata_i[`ASQ_SAMPLE_BIT_BIT];
			ASQ_TRIG_EXTERNAL_INTERRUPT_PIN_ZERO: end_smp = ext_external_interrupt_pin_zero_i && !external_interrupt_pin_zero_q;
			ASQ_TRIG_TMR3: end_smp = timer3_match_i;
			ASQ_TRIG_AUTO: end_smp = tad_tick && smp_cnt_q + 5'h01 >= samc_q;
			default: end_smp = 1'h0;
		endcase
	end

	// A conversion in flight finishes even when frozen or idle
	always_comb begin
		state_d = state_q;
		start_conv = 1'h0;
		if (!on_q) begin
			state_d = ASQ_HOLD;
		end else begin
			unique case (state_q)
				ASQ_HOLD: begin
					if (run && (auto_sample_start_q || (w1 && wdata_i[`ASQ_SAMPLE_BIT_BIT]))) begin
						state_d = ASQ_SAMPLE;
					end
				end
				ASQ_SAMPLE: begin
					if (run && end_smp) begin
						state_d = ASQ_CONVERT;
						start_conv = 1'h1;
					end
				end
				ASQ_CONVERT: begin
					if (conv_done_i) begin
						state_d = ASQ_HOLD;
					end
				end
				default: state_d = ASQ_HOLD;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_q <= ASQ_HOLD;
			sample_o <= 1'h0;
			conv_start_o <= 1'h0;
		end else begin
			state_q <= state_d;
			sample_o <= state_d == ASQ_SAMPLE;
			conv_start_o <= start_conv;
		end
	end

	// Sequence position: fill slot, half, mux side and scan channel
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			seq_q <= 4'h0;
			fill_q <= 4'h0;
			buffer_fill_status_q <= 1'h0;
			use_b_q <= 1'h0;
			scan_idx_q <= 4'h0;
		end else if (irq_ev) begin
			seq_q <= 4'h0;
			fill_q <= 4'h0;
			buffer_fill_status_q <= buffer_fill_status_q ^ buffer_split_mode_q;
			use_b_q <= 1'h0;
			scan_idx_q <= asq_next(cssl_q, 4'hF);
		end else if (cdone) begin
			seq_q <= seq_q + 4'h1;
			fill_q <= fill_q + 4'h1;
			use_b_q <= alternate_input_mode_q && !use_b_q;
			if (!use_b_q) begin
				scan_idx_q <= asq_next(cssl_q, scan_idx_q);
			end
		end else if (w2 || wcs) begin
			// A mask write restarts from the new mask, not the one it replaces
			scan_idx_q <= asq_next(wcs ? wdata_i[15:0] : cssl_q, 4'hF);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 16; i++) begin
				res_q[i] <= 10'h000;
			end
		end else if (cdone) begin
			res_q[widx] <= conv_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			chan_pos_o <= 4'h0;
			offset_cal_o <= 1'h0;
			ref_sel_o <= 2'h0;
		end else begin
			chan_pos_o <= use_b_q ? chsb_q : (scan_en_q ? scan_idx_q : chsa_q);
			offset_cal_o <= offset_calibration_mode_q;
			ref_sel_o <= vcfg_q[2] ? 2'h0 : vcfg_q[1:0];
		end
	end

	asq_fmt u_fmt (
		.form_i(form_q),
		.data_i(res_q[boff[7:4]]),
		.word_o(fmt_word)
	);

	always_comb begin
		unique case (addr_i)
			`ASQ_CON1_ADDR: rd_val = {16'h0000, on_q, frz_q && debug_mode_i, stop_in_idle_q, 2'h0, form_q, trig_q,
				stop_after_first_irq_q, 1'h0, auto_sample_start_q, state_q == ASQ_SAMPLE, done_q};
			`ASQ_CON2_ADDR: rd_val = {16'h0000, vcfg_q, offset_calibration_mode_q, 1'h0, scan_en_q, 2'h0, buffer_fill_status_q, 1'h0,
				smpi_q, buffer_split_mode_q, alternate_input_mode_q};
			`ASQ_CON3_ADDR: rd_val = {16'h0000, adrc_q, 2'h0, samc_q, div_q};
			`ASQ_CHS_ADDR: rd_val = {4'h0, chsb_q, 4'h0, chsa_q, 16'h0000};
			`ASQ_CSSL_ADDR: rd_val = {16'h0000, cssl_q};
			`ASQ_INTERRUPT_FLAG_STATUS_1_ADDR: rd_val = {30'h0000_0000, flag_q, 1'h0};
			`ASQ_INTERRUPT_ENABLE_CONTROL_1_ADDR: rd_val = {30'h0000_0000, ien_q, 1'h0};
			`ASQ_INTERRUPT_PRIORITY_CONTROL_6_ADDR: rd_val = {3'h0, irq_prio_o, irq_sub_o, 24'h00_0000};
			default: rd_val = bhit ? fmt_word : `ASQ_RESET_WORD;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rdata_o <= `ASQ_RESET_WORD;
		end else begin
			rdata_o <= rd_i ? rd_val : `ASQ_RESET_WORD;
		end
	end

	sequence s_auto_done;
		cdone && auto_sample_start_q && !(stop_after_first_irq_q && irq_ev) && !w1;
	endsequence

	chk_off_hold: assert property (!on_q |=> state_q == ASQ_HOLD)
		else $error("converter active while off");
	chk_frz_read: assert property (rd_i && addr_i == `ASQ_CON1_ADDR && !debug_mode_i |=> !rdata_o[14])
		else $error("freeze bit visible outside debug");
	chk_idle_stop: assert property (on_q && stop_in_idle_q && idle_mode_i && state_q != ASQ_CONVERT
		|=> state_q == $past(state_q))
		else $error("sequencer moved in idle");
	chk_sw_end: assert property (run && state_q == ASQ_SAMPLE && trig_q == ASQ_TRIG_SW && w1
		&& !wdata_i[1] |=> state_q == ASQ_CONVERT && conv_start_o)
		else $error("software end of sampling ignored");
	chk_clr_auto_sample_start: assert property (irq_ev && stop_after_first_irq_q |=> !auto_sample_start_q)
		else $error("auto start survived first interrupt");
	chk_done_set: assert property (cdone |=> done_q [*1] ##1 (done_q || state_q == ASQ_SAMPLE || $past(w1)))
		else $error("done not held after completion");
	chk_irq_rate: assert property (cdone && seq_q == smpi_q |=> flag_q ##1 (irq_req_o == ien_q || $past(wen)))
		else $error("interrupt not raised at sequence count");
	chk_auto_start: assert property (s_auto_done ##1 (run && auto_sample_start_q && !w1)
		|=> state_q == ASQ_SAMPLE && !done_q && sample_o)
		else $error("auto resample or done clear missing");
	chk_ref_map: assert property (##1 ref_sel_o == ($past(vcfg_q[2]) ? 2'h0 : $past(vcfg_q[1:0])))
		else $error("reference select mismatch");
endmodule

// file: verif/asq_core_model.sv
`timescale 1ns/10ps
module asq_core_model #(parameter int LAT = 3) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic [9:0] value_i,
	output logic done_o,
	output logic [9:0] data_o
);
	int cnt = 0;
	// Data toggles outside the done pulse so a stale value never looks valid
	always @(posedge ref_clk_i) begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (!nrst_i) begin
			cnt <= 0;
			data_o <= 10'h000;
		end else if (start_i) begin
			cnt <= LAT;
		end else if (cnt == 1) begin
			done_o <= 1'b1;
			data_o <= value_i;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/10ps
`include "asq_defines.svh"
module tb_top;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [31:0] addr_i = 32'h0000_0000;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic debug_mode_i = 1'b0;
	logic idle_mode_i = 1'b0;
	logic timer3_match_i = 1'b0;
	logic ext_external_interrupt_pin_zero_i = 1'b0;
	logic conv_done_i;
	logic [9:0] conv_data_i;
	logic [9:0] value_q = 10'h2a5;
	logic [31:0] rdata_o;
	logic sample_o, conv_start_o, offset_cal_o, irq_req_o;
	logic [3:0] chan_pos_o;
	logic [1:0] ref_sel_o, irq_sub_o;
	logic [2:0] irq_prio_o;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	asq_top u_dut (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.debug_mode_i(debug_mode_i),
		.idle_mode_i(idle_mode_i),
		.timer3_match_i(timer3_match_i),
		.ext_external_interrupt_pin_zero_i(ext_external_interrupt_pin_zero_i),
		.conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i),
		.rdata_o(rdata_o),
		.sample_o(sample_o),
		.conv_start_o(conv_start_o),
		.chan_pos_o(chan_pos_o),
		.offset_cal_o(offset_cal_o),
		.ref_sel_o(ref_sel_o),
		.irq_req_o(irq_req_o),
		.irq_prio_o(irq_prio_o),
		.irq_sub_o(irq_sub_o)
	);
	asq_core_model u_core (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.start_i(conv_start_o),
		.value_i(value_q),
		.done_o(conv_done_i),
		.data_o(conv_data_i)
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic bw(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [31:0] a, input logic [31:0] e, input string m);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, e, m);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Called just after an edge, so the start pulse of that cycle is seen
	// Extra cycles let the model finish the conversion before returning
	task automatic wait_cs(input int n, input logic e, input string m);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			#1;
			if (conv_start_o === 1'b1) seen = 1'b1;
			@(posedge ref_clk_i);
		end
		chk({31'h0, seen}, {31'h0, e}, m);
		settle(8);
	endtask
	function automatic logic [31:0] fmt(input logic [2:0] f, input logic [9:0] d);
		logic [9:0] s;
		s = {~d[9], d[8:0]};
		case (f)
			3'h2: return {16'h0, d, 6'h0};
			3'h3: return {16'h0, s, 6'h0};
			3'h5: return {{22{s[9]}}, s};
			3'h7: return {s, 22'h0};
			default: return {22'h0, d};
		endcase
	endfunction
	task automatic t_regs();
		rc(`ASQ_CON1_ADDR, 32'h0000_0000, "con1 reset");
		bw(`ASQ_CON1_ADDR, 32'h0000_4000);
		rc(`ASQ_CON1_ADDR, 32'h0000_0000, "freeze normal");
		@(posedge ref_clk_i);
		debug_mode_i <= 1'b1;
		bw(`ASQ_CON1_ADDR, 32'h0000_4000);
		rc(`ASQ_CON1_ADDR, 32'h0000_4000, "freeze debug");
		@(posedge ref_clk_i);
		debug_mode_i <= 1'b0;
		bw(`ASQ_CON2_ADDR, 32'h0000_0083);
		rc(`ASQ_CON2_ADDR, 32'h0000_0003, "fill status ro");
		rc(32'hBF80_9004, 32'h0000_0000, "unmapped");
		$display("test regs done");
	endtask
	task automatic t_ref();
		for (int i = 0; i < 8; i++) begin
			bw(`ASQ_CON2_ADDR, {16'h0, i[2:0], i[0], 12'h0});
			settle(2);
			chk({30'h0, ref_sel_o}, {30'h0, i[2] ? 2'h0 : i[1:0]}, "ref sel");
			chk({31'h0, offset_cal_o}, {31'h0, i[0]}, "offset_calibration_mode");
		end
		$display("test ref done");
	endtask
	task automatic t_manual();
		logic [2:0] fl [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
		// The on bit must already be set when the sample request arrives
		bw(`ASQ_CON1_ADDR, 32'h0000_8000);
		bw(`ASQ_CON1_ADDR, 32'h0000_8002);
		settle(2);
		chk({31'h0, sample_o}, 32'h0000_0001, "sampling");
		bw(`ASQ_CON1_ADDR, 32'h0000_8000);
		wait_cs(4, 1'b1, "sw trigger");
		rc(`ASQ_CON1_ADDR, 32'h0000_8001, "done set");
		foreach (fl[k]) begin
			bw(`ASQ_CON1_ADDR, {16'h0, 5'h10, fl[k], 8'h00});
			rc(`ASQ_BUF0_ADDR, fmt(fl[k], 10'h2a5), "format");
		end
		$display("test manual done");
	endtask
	task automatic t_auto();
		int n;
		int s;
		n = 0;
		s = 0;
		bw(`ASQ_INTERRUPT_ENABLE_CONTROL_1_ADDR, 32'h0000_0002);
		bw(`ASQ_INTERRUPT_PRIORITY_CONTROL_6_ADDR, 32'h1700_0000);
		bw(`ASQ_CON3_ADDR, 32'h0000_0200);
		bw(`ASQ_CON2_ADDR, 32'h0000_0004);
		bw(`ASQ_INTERRUPT_FLAG_STATUS_1_ADDR, 32'h0000_0000);
		bw(`ASQ_CON1_ADDR, 32'h0000_80F4);
		repeat (80) begin
			settle(1);
			if (sample_o === 1'b1) s++;
			if (conv_start_o === 1'b1) begin
				n++;
				value_q = value_q + 10'h001;
			end
		end
		chk(n, 2, "auto sequences");
		// Two sequences of two 2-clock periods, plus the entry cycle each
		chk(s, 2 * (2 * 2 + 1), "sample cycles");
		chk({31'h0, irq_req_o}, 32'h0000_0001, "irq req");
		chk({27'h0, irq_prio_o, irq_sub_o}, 32'h0000_0017, "irq prio");
		rc(`ASQ_INTERRUPT_FLAG_STATUS_1_ADDR, 32'h0000_0002, "flag");
		rc(`ASQ_CON1_ADDR, 32'h0000_80F1, "auto start cleared");
		rc(`ASQ_BUF0_ADDR, 32'h0000_02a6, "word 0");
		rc(`ASQ_BUF0_ADDR + 32'h0000_0010, 32'h0000_02a7, "word 1");
		bw(`ASQ_CON1_ADDR, 32'h0000_0000);
		bw(`ASQ_INTERRUPT_FLAG_STATUS_1_ADDR, 32'h0000_0000);
		settle(2);
		chk({31'h0, irq_req_o}, 32'h0000_0000, "irq cleared");
		$display("test auto done");
	endtask
	task automatic t_trig();
		logic [2:0] tl [3] = '{3'h2, 3'h1, 3'h3};
		bw(`ASQ_CON1_ADDR, 32'h0000_8000);
		foreach (tl[k]) begin
			bw(`ASQ_CON1_ADDR, {24'h80, tl[k], 5'h02});
			@(posedge ref_clk_i);
			timer3_match_i <= 1'b1;
			ext_external_interrupt_pin_zero_i <= 1'b1;
			@(posedge ref_clk_i);
			timer3_match_i <= 1'b0;
			ext_external_interrupt_pin_zero_i <= 1'b0;
			wait_cs(5, tl[k] != 3'h3, "hw trigger");
		end
		chk({31'h0, sample_o}, 32'h0000_0001, "reserved holds");
		bw(`ASQ_CON1_ADDR, 32'h0000_0000);
		settle(2);
		chk({31'h0, sample_o}, 32'h0000_0000, "off");
		$display("test trig done");
	endtask
	task automatic t_idle();
		bw(`ASQ_CON1_ADDR, 32'h0000_A000);
		@(posedge ref_clk_i);
		idle_mode_i <= 1'b1;
		bw(`ASQ_CON1_ADDR, 32'h0000_A002);
		settle(2);
		chk({31'h0, sample_o}, 32'h0000_0000, "idle stop");
		@(posedge ref_clk_i);
		idle_mode_i <= 1'b0;
		debug_mode_i <= 1'b1;
		bw(`ASQ_CON1_ADDR, 32'h0000_C002);
		settle(2);
		chk({31'h0, sample_o}, 32'h0000_0000, "frozen in debug");
		@(posedge ref_clk_i);
		debug_mode_i <= 1'b0;
		bw(`ASQ_CON1_ADDR, 32'h0000_A002);
		settle(2);
		chk({31'h0, sample_o}, 32'h0000_0001, "idle resume");
		bw(`ASQ_CON1_ADDR, 32'h0000_0000);
		$display("test idle done");
	endtask
	// One software-started, software-ended conversion, then time to finish
	task automatic conv_sw();
		bw(`ASQ_CON1_ADDR, 32'h0000_8002);
		bw(`ASQ_CON1_ADDR, 32'h0000_8000);
		settle(8);
	endtask
	task automatic t_chan();
		bw(`ASQ_CON1_ADDR, 32'h0000_8000);
		bw(`ASQ_CHS_ADDR, 32'h0905_0000);
		bw(`ASQ_CSSL_ADDR, 32'h0000_0050);
		bw(`ASQ_CON2_ADDR, 32'h0000_0404);
		settle(2);
		chk({28'h0, chan_pos_o}, 32'h0000_0004, "scan first");
		conv_sw();
		chk({28'h0, chan_pos_o}, 32'h0000_0006, "scan next");
		conv_sw();
		chk({28'h0, chan_pos_o}, 32'h0000_0004, "scan restart");
		bw(`ASQ_CON2_ADDR, 32'h0000_0007);
		settle(2);
		chk({28'h0, chan_pos_o}, 32'h0000_0005, "mux a first");
		conv_sw();
		chk({28'h0, chan_pos_o}, 32'h0000_0009, "mux b");
		conv_sw();
		chk({28'h0, chan_pos_o}, 32'h0000_0005, "mux a again");
		rc(`ASQ_CON2_ADDR, 32'h0000_0087, "fill status split");
		bw(`ASQ_CON1_ADDR, 32'h0000_0000);
		$display("test chan done");
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_ref();
		t_manual();
		t_auto();
		t_trig();
		t_idle();
		t_chan();
		complete_run();
	end
endmodule
